// ---- pkg/nvm_defines.vh ----
// constants for the two-wire byte memory slave
// assumes inclusion by bare name from the logic files
`ifndef NVM_DEFINES_VH
`define NVM_DEFINES_VH

// memory geometry
`define NVM_ADDR_W 17
`define NVM_DEPTH 131072
`define NVM_ADDR_RST 17'h00000

// slave address byte layout
`define NVM_TYPE_MSB 7
`define NVM_TYPE_LSB 4
`define NVM_TYPE_ID 4'hA
`define NVM_SEL_MSB 3
`define NVM_SEL_LSB 2
`define NVM_PAGE_BIT 1
`define NVM_RW_BIT 0

// high-speed master code, upper five bits
`define NVM_HS_MSB 7
`define NVM_HS_LSB 3
`define NVM_HS_CODE 5'h01

// bit counter
`define NVM_LAST_BIT 4'h7
`define NVM_BYTE_DONE 4'h8

// synchroniser reset levels
`define NVM_BUS_IDLE 2'h3
`define NVM_PIN_RST 3'h0

`endif

// ---- logic/nvm_sync.v ----
// three-flop input synchroniser with agreement filter
// assumes inputs come from outside the mclk domain
`timescale 1ns/1ns

module nvm_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// clock and reset
	input wire mclk,
	input wire rstn,
	// raw and filtered levels
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] s1_r;
	reg [WIDTH-1:0] s2_r;
	reg [WIDTH-1:0] s3_r;

	// a bit moves only once stages two and three agree, so single-sample glitches never pass
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			dout <= (s2_r & s3_r) | (dout & (s2_r ^ s3_r));
		end
	end

endmodule

// ---- logic/nvm_i2c_slave.v ----
// two-wire slave front end of a 128K x 8 nonvolatile byte memory, array included
// assumes scl, sda and pins arrive asynchronously; sda pad is open drain, low when sda_oe is high
`timescale 1ns/1ns
`include "nvm_defines.vh"

module nvm_i2c_slave #(
	parameter ADDR_W = `NVM_ADDR_W,
	parameter DEPTH = `NVM_DEPTH
) (
	// clock and reset
	input wire mclk,
	input wire rstn,
	// two-wire bus pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output reg sda_oe,
	// device pins
	input wire [1:0] chip_select_straps,
	input wire write_protect,
	// status
	output reg hs_mode,
	output wire selected
);

	localparam [8:0] ST_IDLE = 9'h001;
	localparam [8:0] ST_DEV = 9'h002;
	localparam [8:0] ST_AHI = 9'h004;
	localparam [8:0] ST_ALO = 9'h008;
	localparam [8:0] ST_WDAT = 9'h010;
	localparam [8:0] ST_ACKT = 9'h020;
	localparam [8:0] ST_RDAT = 9'h040;
	localparam [8:0] ST_ACKR = 9'h080;
	localparam [8:0] ST_RSTRT = 9'h100;

	// wraps naturally at the register width
	function [ADDR_W-1:0] addr_inc;
		input [ADDR_W-1:0] a;
		begin
			addr_inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
		end
	endfunction

	reg [7:0] mem [0:DEPTH-1];

	wire scl_f;
	wire sda_f;
	wire [1:0] straps_f;
	wire wp_f;
	reg scl_q_r;
	reg sda_q_r;

	reg [8:0] state_r;
	reg [8:0] next_r;
	reg [3:0] bitcnt_r;
	reg [7:0] shreg_r;
	reg [ADDR_W-1:0] addr_r;
	reg rd_r;
	reg ack_ok_r;
	reg ack_ph_r;

	reg byte_ok;
	reg [8:0] byte_next;

	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire [7:0] rx_byte;
	wire [7:0] rd_byte;
	wire dev_match;
	wire hs_code;
	wire mem_we;

	// scl and sda travel together so their relative order is kept
	nvm_sync #(
		.WIDTH(2),
		.RST_VAL(`NVM_BUS_IDLE)
	) u_bus_sync (
		.mclk(mclk),
		.rstn(rstn),
		.din({scl_in, sda_in}),
		.dout({scl_f, sda_f})
	);

	nvm_sync #(
		.WIDTH(3),
		.RST_VAL(`NVM_PIN_RST)
	) u_pin_sync (
		.mclk(mclk),
		.rstn(rstn),
		.din({chip_select_straps, write_protect}),
		.dout({straps_f, wp_f})
	);

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_f;
			sda_q_r <= sda_f;
		end
	end

	assign scl_rise = scl_f & ~scl_q_r;
	assign scl_fall = ~scl_f & scl_q_r;
	// sda moving while scl stays high is a condition, never data
	assign start_det = scl_f & scl_q_r & sda_q_r & ~sda_f;
	assign stop_det = scl_f & scl_q_r & ~sda_q_r & sda_f;

	assign rx_byte = {shreg_r[6:0], sda_f};
	assign rd_byte = mem[addr_r];
	assign sda_out = 1'b0;
	assign selected = (state_r != ST_IDLE);

	assign dev_match = (rx_byte[`NVM_TYPE_MSB:`NVM_TYPE_LSB] == `NVM_TYPE_ID) &&
		(rx_byte[`NVM_SEL_MSB:`NVM_SEL_LSB] == straps_f);
	assign hs_code = (rx_byte[`NVM_HS_MSB:`NVM_HS_LSB] == `NVM_HS_CODE);

	// commit on the eighth rising edge; an earlier start or stop leaves the array alone
	assign mem_we = scl_rise & ~start_det & ~stop_det & (state_r == ST_WDAT) &
		(bitcnt_r == `NVM_LAST_BIT) & ~wp_f;

	// decision taken when the eighth bit of a received byte lands
	always @* begin
		byte_ok = 1'b0;
		byte_next = ST_IDLE;
		case (state_r)
			ST_DEV: begin
				byte_ok = dev_match;
				byte_next = rx_byte[`NVM_RW_BIT] ? ST_RSTRT : ST_AHI;
			end
			ST_AHI: begin
				byte_ok = 1'b1;
				byte_next = ST_ALO;
			end
			ST_ALO: begin
				byte_ok = 1'b1;
				byte_next = ST_WDAT;
			end
			ST_WDAT: begin
				byte_ok = ~wp_f;
				byte_next = ST_WDAT;
			end
			default: begin
				byte_ok = 1'b0;
				byte_next = ST_IDLE;
			end
		endcase
	end

	// no page buffer and no write cycle: the byte lands within one mclk
	always @(posedge mclk) begin
		if (mem_we) begin
			mem[addr_r] <= rx_byte;
		end
	end

	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			next_r <= ST_IDLE;
			bitcnt_r <= 4'h0;
			shreg_r <= 8'h00;
			addr_r <= `NVM_ADDR_RST;
			rd_r <= 1'b0;
			ack_ok_r <= 1'b0;
			ack_ph_r <= 1'b0;
			sda_oe <= 1'b0;
			hs_mode <= 1'b0;
		end else if (stop_det) begin
			state_r <= ST_IDLE;
			sda_oe <= 1'b0;
			bitcnt_r <= 4'h0;
			ack_ph_r <= 1'b0;
			hs_mode <= 1'b0;
		end else if (start_det) begin
			// any partial write or read is dropped; the address latch keeps what it has
			state_r <= ST_DEV;
			sda_oe <= 1'b0;
			bitcnt_r <= 4'h0;
			ack_ph_r <= 1'b0;
		end else begin
			case (state_r)
				ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
					if (scl_rise) begin
						shreg_r <= rx_byte;
						bitcnt_r <= bitcnt_r + 4'h1;
						if (bitcnt_r == `NVM_LAST_BIT) begin
							bitcnt_r <= 4'h0;
							ack_ph_r <= 1'b0;
							ack_ok_r <= byte_ok;
							next_r <= byte_next;
							state_r <= ST_ACKT;
							if (state_r == ST_DEV) begin
								if (hs_code) begin
									// master code is never acknowledged; a restart follows
									hs_mode <= 1'b1;
									ack_ok_r <= 1'b0;
								end
								if (dev_match) begin
									addr_r[ADDR_W-1] <= rx_byte[`NVM_PAGE_BIT];
									rd_r <= rx_byte[`NVM_RW_BIT];
								end
							end
							if (state_r == ST_AHI) begin
								addr_r[15:8] <= rx_byte;
							end
							if (state_r == ST_ALO) begin
								addr_r[7:0] <= rx_byte;
							end
							if ((state_r == ST_WDAT) && !wp_f) begin
								addr_r <= addr_inc(addr_r);
							end
						end
					end
				end
				ST_ACKT: begin
					if (scl_fall) begin
						if (!ack_ph_r) begin
							sda_oe <= ack_ok_r;
							ack_ph_r <= 1'b1;
							if (!ack_ok_r) begin
								state_r <= ST_IDLE;
							end
						end else begin
							ack_ph_r <= 1'b0;
							if (rd_r) begin
								// first read bit goes out on the same fall that ends the ack
								shreg_r <= rd_byte;
								sda_oe <= ~rd_byte[7];
								bitcnt_r <= 4'h0;
								state_r <= ST_RDAT;
							end else begin
								sda_oe <= 1'b0;
								state_r <= next_r;
							end
						end
					end
				end
				ST_RDAT: begin
					if (scl_rise) begin
						bitcnt_r <= bitcnt_r + 4'h1;
						if (bitcnt_r == `NVM_LAST_BIT) begin
							addr_r <= addr_inc(addr_r);
						end
					end else if (scl_fall) begin
						if (bitcnt_r == `NVM_BYTE_DONE) begin
							sda_oe <= 1'b0;
							bitcnt_r <= 4'h0;
							state_r <= ST_ACKR;
						end else begin
							shreg_r <= {shreg_r[6:0], 1'b0};
							sda_oe <= ~shreg_r[6];
						end
					end
				end
				ST_ACKR: begin
					if (scl_rise) begin
						// a master ack asks for another byte; without it we let go
						state_r <= sda_f ? ST_IDLE : ST_RSTRT;
					end
				end
				ST_RSTRT: begin
					if (scl_fall) begin
						shreg_r <= rd_byte;
						sda_oe <= ~rd_byte[7];
						bitcnt_r <= 4'h0;
						state_r <= ST_RDAT;
					end
				end
				ST_IDLE: begin
					sda_oe <= 1'b0;
					bitcnt_r <= 4'h0;
				end
				default: begin
					state_r <= ST_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ---- dv/nvm_i2c_slave_assertions.sv ----
// port checker for the two-wire memory slave
// assumes sda_in is the resolved pulled-up wire
`timescale 1ns/1ns
module nvm_i2c_slave_chk (
	// clock and reset
	input wire mclk,
	input wire rstn,
	// link
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	// pins and status
	input wire [1:0] chip_select_straps,
	input wire write_protect,
	input wire hs_mode,
	input wire selected
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_drive_low: assert property (sda_out == 1'b0)
		else $error("sda_out high");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda_oe moved with scl high");
	a_oe_holds: assert property ($rose(sda_oe) |-> sda_oe[*8])
		else $error("ack too short");
	a_idle_quiet: assert property (!selected |-> !sda_oe)
		else $error("idle device drives sda");
	a_start_sel: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:10] selected)
		else $error("start missed");
	a_stop_idle: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:10] !selected)
		else $error("stop missed");
	a_stop_hs: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:10] !hs_mode)
		else $error("hs kept after stop");
	a_hs_fell: assert property ($fell(hs_mode) |-> scl_in)
		else $error("hs cleared without stop");
endmodule
bind nvm_i2c_slave nvm_i2c_slave_chk nvm_i2c_slave_chk_i (.mclk(mclk), .rstn(rstn), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
	.write_protect(write_protect), .hs_mode(hs_mode), .selected(selected));

// ---- dv/nvm_master.sv ----
// link master model driving scl and pulling sda
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ns
module nvm_master (
	// link
	output logic scl,
	output logic sda_low,
	input wire sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// scl low 63 ns, high 62 ns
	task automatic bit_out(input logic b, output logic r);
		#20 sda_low <= !b;
		#43 scl <= 1'b1;
		#31 r = sda;
		#31 scl <= 1'b0;
	endtask
	task automatic start();
		#20 sda_low <= 1'b0;
		#43 scl <= 1'b1;
		#31 sda_low <= 1'b1;
		#31 scl <= 1'b0;
	endtask
	task automatic stop();
		#20 sda_low <= 1'b1;
		#43 scl <= 1'b1;
		#31 sda_low <= 1'b0;
	endtask
	// one scl pulse narrower than an mclk period, only while scl is low
	task automatic spike();
		#10 scl <= 1'b1;
		#6 scl <= 1'b0;
	endtask
	// ack_in high leaves the ninth slot released
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i], ack);
			q[i] = ack;
		end
		bit_out(ack_in, ack);
	endtask
endmodule

// ---- dv/nvm_i2c_slave_test.sv ----
// bench for the two-wire memory slave
// assumes nvm_master drives the link
`timescale 1ns/1ns
module nvm_i2c_slave_test;
	logic mclk, rstn, wp, sda_oe, hs_mode, selected, a;
	logic [1:0] straps;
	logic [7:0] q;
	wire scl, m_low;
	wire sda = !(m_low || sda_oe);
	int err_count, total_checks;
	nvm_i2c_slave nvm_i2c_slave_i (.mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(sda_oe), .chip_select_straps(straps), .write_protect(wp), .hs_mode(hs_mode), .selected(selected));
	nvm_master nvm_master_i (.scl(scl), .sda_low(m_low), .sda(sda));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tx(input logic [7:0] d, input logic ack);
		nvm_master_i.xfer(d, 1'b1, q, a);
		chk("ack", {7'h0, ack}, {7'h0, !a});
	endtask
	task automatic rx(input logic [7:0] e, input logic ack);
		nvm_master_i.xfer(8'hFF, !ack, q, a);
		chk("data", e, q);
	endtask
	task automatic quiet();
		#100;
		@(negedge mclk);
		chk("busy", 8'h0, {6'h0, selected, sda_oe});
	endtask
	task automatic idle();
		nvm_master_i.stop();
		quiet();
	endtask
	task automatic seek(input logic [16:0] ad);
		nvm_master_i.start();
		tx({4'hA, 2'h2, ad[16], 1'b0}, 1'b1);
		tx(ad[15:8], 1'b1);
		tx(ad[7:0], 1'b1);
	endtask
	task automatic t_wrap();
		seek(17'h1FFFE);
		tx(8'h11, 1'b1);
		tx(8'h22, 1'b1);
		tx(8'h33, 1'b1);
		idle();
		seek(17'h1FFFE);
		nvm_master_i.start();
		tx(8'hAB, 1'b1);
		rx(8'h11, 1'b1);
		rx(8'h22, 1'b1);
		rx(8'h33, 1'b0);
		quiet();
		idle();
	endtask
	task automatic t_refuse();
		nvm_master_i.start();
		tx(8'hA6, 1'b0);
		quiet();
		nvm_master_i.start();
		tx(8'h58, 1'b0);
		idle();
		@(posedge mclk) straps <= 2'h1;
		nvm_master_i.start();
		tx(8'hA6, 1'b1);
		idle();
		@(posedge mclk) straps <= 2'h2;
	endtask
	task automatic t_protect();
		seek(17'h00010);
		tx(8'h77, 1'b1);
		idle();
		@(posedge mclk) wp <= 1'b1;
		seek(17'h00010);
		tx(8'h5A, 1'b0);
		idle();
		@(posedge mclk) wp <= 1'b0;
		nvm_master_i.start();
		tx(8'hA9, 1'b1);
		rx(8'h77, 1'b0);
		idle();
	endtask
	// five bits then stop: the byte never lands and the latch stays put
	task automatic t_abort();
		seek(17'h00030);
		tx(8'h44, 1'b1);
		seek(17'h00030);
		for (int i = 7; i >= 3; i--)
			nvm_master_i.bit_out(i[0], a);
		idle();
		nvm_master_i.start();
		tx(8'hA9, 1'b1);
		rx(8'h44, 1'b0);
		idle();
	endtask
	// a narrow scl pulse must not count as a bit
	task automatic t_spike();
		seek(17'h00020);
		nvm_master_i.spike();
		tx(8'h3C, 1'b1);
		seek(17'h00020);
		nvm_master_i.start();
		tx(8'hA9, 1'b1);
		rx(8'h3C, 1'b0);
		idle();
	endtask
	task automatic t_hs();
		nvm_master_i.start();
		tx(8'h0B, 1'b0);
		chk("hs", 8'h1, {7'h0, hs_mode});
		idle();
		chk("hs", 8'h0, {7'h0, hs_mode});
	endtask
	task automatic end_sim();
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		wp = 1'b0;
		straps = 2'h2;
		err_count = 0;
		total_checks = 0;
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		repeat (12) @(posedge mclk);
		t_wrap();
		t_refuse();
		t_protect();
		t_abort();
		t_spike();
		t_hs();
		end_sim();
	end
	// about 60 us of traffic expected
	initial begin
		#200000;
		err_count++;
		end_sim();
	end
endmodule
